// file: core/synth_consts.svh
// Purpose: Bit positions, addresses and reset values of the control words
// Assumes: 22-bit serial word, address in the two low bits
// Notes: Included by the package, serial_shift and channel_control
`ifndef SYNTH_CONSTS_SVH
`define SYNTH_CONSTS_SVH
`define WORD_BITS 22
`define ADDR_SECOND_REF 2'h0
`define ADDR_SECOND_FB 2'h1
`define ADDR_FIRST_REF 2'h2
`define ADDR_FIRST_FB 2'h3
`define REF_DIV_LSB 2
`define REF_DIV_MSB 16
`define REF_POL_BIT 17
`define REF_GAIN_BIT 18
`define REF_HIZ_BIT 19
`define REF_SEL_HI_BIT 20
`define REF_SEL_LO_BIT 21
`define FB_SWALLOW_LSB 2
`define FB_SWALLOW_MSB 8
`define FB_BINARY_LSB 9
`define FB_BINARY_MSB 19
`define FB_PRESCALE_BIT 20
`define FB_POWERDOWN_BIT 21
`define WORD_RESET 22'h000000
`define REF_DIV_MIN 15'h0003
`define FB_BINARY_MIN 11'h003
`define SEL_LOW 4'h0
`define SEL_SECOND_REF_A 4'h1
`define SEL_FIRST_REF_A 4'h2
`define SEL_FAST_LOCK 4'h3
`define SEL_SECOND_LOCK 4'h4
`define SEL_SECOND_FB_A 4'h5
`define SEL_FIRST_FB_A 4'h6
`define SEL_RESET_SECOND 4'h7
`define SEL_FIRST_LOCK 4'h8
`define SEL_SECOND_REF_B 4'h9
`define SEL_FIRST_REF_B 4'ha
`define SEL_RESET_FIRST 4'hb
`define SEL_BOTH_LOCK 4'hc
`define SEL_SECOND_FB_B 4'hd
`define SEL_FIRST_FB_B 4'he
`define SEL_RESET_ALL 4'hf
`endif

// file: core/synth_pkg.sv
// Purpose: Types shared by the control word modules
// Assumes: Constants come from synth_consts.svh
// Notes: Holds types only
`include "synth_consts.svh"
package synth_pkg;
    typedef struct packed {
        logic [1:0] addr;
        logic [`WORD_BITS-1:0] word;
    } load_t;
    typedef struct packed {
        logic channel_powerdown;
        logic prescaler_128;
        logic [10:0] binary_feedback_count;
        logic [6:0] swallow_count;
        logic hiz;
        logic charge_pump_gain_select;
        logic phase_detector_polarity;
        logic [14:0] reference_divider_value;
    } channel_cfg_t;
    typedef enum logic [3:0] {
        pd_active = 4'h1,
        pd_hiz = 4'h2,
        pd_sync = 4'h4,
        pd_async = 4'h8
    } pd_state_t;
endpackage

// file: core/serial_shift.sv
// Purpose: Three-wire link shifter on the link clock
// Assumes: Data sampled on rising link clock, MSB first
// Notes: Holds last 22 bits; the word crosses on latch_enable rise
`timescale 1ns/1ps
`include "synth_consts.svh"
module serial_shift (
    input wire logic link_clk, // Serial clock from the host
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic data_in, // Serial data
    output logic [`WORD_BITS-1:0] shift_q // Shifted word
);
    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            shift_q <= `WORD_RESET;
        end else begin
            shift_q <= {shift_q[`WORD_BITS-2:0], data_in};
        end
    end
endmodule

// file: core/sync2.sv
// Purpose: Two flip-flop level synchroniser
// Assumes: Destination clock is ref_clk
// Notes: First stage feeds only the second
`timescale 1ns/1ps
module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk, // Destination clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic [WIDTH-1:0] async_in, // Level from other domain
    output logic [WIDTH-1:0] sync_q // Synchronised level
);
    logic [WIDTH-1:0] meta_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
endmodule

// file: core/channel_control.sv
// Purpose: Control words of the first channel and the output selector
// Assumes: latch_enable rises only after the last data bit's clock edge
// Notes: Shift word is stable while latch_enable is high; it is taken
// Notes: in ref_clk after latch_enable passes two flip-flops
`timescale 1ns/1ps
`include "synth_consts.svh"
// Functional notes
// - Reference divider divides by 15-bit value
// - Bit 17 selects phase detector polarity
// - Bit 18 selects charge pump gain
// - Bit 19 sets charge pump high impedance immediately
// - High impedance bit picks powerdown sync/async
// - Swallow count is 7 bits, 0 to 127
// - Binary feedback count 11 bits, 3 to 2047
// - Bit 20 picks 64/65 or 128/129 prescaler
// - Bit 21 powers the first channel down
// - Select word built from four reference bits
// - Low codes, some also hold counters reset
// - Divider codes drive pin push-pull
// - Lock detect codes drive pin push-pull
// - Code 0011 gives open-drain fast-lock output
// - MSB-first word loaded on latch_enable rise
// - Two address bits select target register
// - Four powerdown states from two bits
module channel_control (
    input wire logic ref_clk, // System clock, 50 MHz
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic link_clk, // Serial clock from the host
    input wire logic serial_data, // Serial data pin
    input wire logic latch_enable, // Latch pin, load on rise
    input wire logic first_ref_div_out, // First channel reference divider
    input wire logic first_fb_div_out, // First channel feedback divider
    input wire logic second_ref_div_out, // Second channel reference divider
    input wire logic second_fb_div_out, // Second channel feedback divider
    input wire logic first_lock, // First channel lock detect
    input wire logic second_lock, // Second channel lock detect
    input wire logic fast_lock_active, // Fast-lock phase in progress
    output synth_pkg::channel_cfg_t first_cfg, // First channel settings
    output synth_pkg::pd_state_t first_pd_state, // First channel power state
    output logic charge_pump_hiz, // First charge pump high impedance
    output logic [3:0] multi_function_output_select, // Select word
    output logic mf_out, // Multi-function pin output level
    output logic mf_oe, // Multi-function pin output enable
    output logic first_counter_reset, // Hold first channel counters
    output logic second_counter_reset, // Hold second channel counters
    output logic second_ref_bit20, // Second reference word bit 20
    output logic second_ref_bit21 // Second reference word bit 21
);
    logic [`WORD_BITS-1:0] shift_word;
    logic [`WORD_BITS-1:0] word_q;
    logic [`WORD_BITS-1:0] first_ref_q;
    logic [`WORD_BITS-1:0] first_fb_q;
    logic second_sel_hi_q;
    logic second_sel_lo_q;
    logic load_q;
    logic latch_sync;
    logic latch_prev_q;
    logic [6:0] div_sync;
    logic latch_rise;
    synth_pkg::load_t load;
    synth_pkg::channel_cfg_t cfg_d;
    synth_pkg::pd_state_t pd_d;
    logic [3:0] sel_d;
    logic out_d;
    logic oe_d;
    logic rst_first_d;
    logic rst_second_d;

    serial_shift u_shift (
        .link_clk(link_clk),
        .nrst(nrst),
        .data_in(serial_data),
        .shift_q(shift_word)
    );

    sync2 #(.WIDTH(1)) u_latch_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .async_in(latch_enable),
        .sync_q(latch_sync)
    );

    sync2 #(.WIDTH(7)) u_in_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .async_in({first_ref_div_out, first_fb_div_out,
                   second_ref_div_out, second_fb_div_out,
                   first_lock, second_lock, fast_lock_active}),
        .sync_q(div_sync)
    );

    // The shift word is frozen while latch_enable is high, so the sampled
    // copy below is stable by the time the synchronised rise is seen
    assign latch_rise = latch_sync && !latch_prev_q;
    assign load = {word_q[1:0], word_q};

    wire load_first_ref = load_q && load.addr == `ADDR_FIRST_REF;
    wire load_first_fb = load_q && load.addr == `ADDR_FIRST_FB;
    wire load_second_ref = load_q && load.addr == `ADDR_SECOND_REF;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            latch_prev_q <= 1'b0;
            word_q <= `WORD_RESET;
            load_q <= 1'b0;
        end else begin
            latch_prev_q <= latch_sync;
            load_q <= latch_rise;
            if (latch_rise) begin
                // Capture after crossing: word held steady during latch
                word_q <= shift_word;
            end
        end
    end

    // Registers only change on a decoded load, never on shifting alone
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            first_ref_q <= `WORD_RESET;
            first_fb_q <= `WORD_RESET;
            second_sel_hi_q <= 1'b0;
            second_sel_lo_q <= 1'b0;
        end else begin
            if (load_first_ref) begin
                first_ref_q <= load.word;
            end
            if (load_first_fb) begin
                first_fb_q <= load.word;
            end
            if (load_second_ref) begin
                second_sel_hi_q <= load.word[`REF_SEL_HI_BIT];
                second_sel_lo_q <= load.word[`REF_SEL_LO_BIT];
            end
        end
    end

    // Field extraction of the first channel words
    always_comb begin
        cfg_d.reference_divider_value =
            first_ref_q[`REF_DIV_MSB:`REF_DIV_LSB];
        cfg_d.phase_detector_polarity = first_ref_q[`REF_POL_BIT];
        cfg_d.charge_pump_gain_select = first_ref_q[`REF_GAIN_BIT];
        cfg_d.hiz = first_ref_q[`REF_HIZ_BIT];
        cfg_d.swallow_count =
            first_fb_q[`FB_SWALLOW_MSB:`FB_SWALLOW_LSB];
        cfg_d.binary_feedback_count =
            first_fb_q[`FB_BINARY_MSB:`FB_BINARY_LSB];
        cfg_d.prescaler_128 = first_fb_q[`FB_PRESCALE_BIT];
        cfg_d.channel_powerdown = first_fb_q[`FB_POWERDOWN_BIT];
    end

    // Power state from high impedance and powerdown bits
    always_comb begin
        case ({cfg_d.hiz, cfg_d.channel_powerdown})
            2'b00: pd_d = synth_pkg::pd_active;
            2'b10: pd_d = synth_pkg::pd_hiz;
            2'b01: pd_d = synth_pkg::pd_sync;
            default: pd_d = synth_pkg::pd_async;
        endcase
    end

    assign sel_d = {first_ref_q[`REF_SEL_HI_BIT], second_sel_hi_q,
                    first_ref_q[`REF_SEL_LO_BIT], second_sel_lo_q};

    wire [6:0] s = div_sync;
    // s: 6 first ref, 5 first fb, 4 second ref, 3 second fb,
    // 2 first lock, 1 second lock, 0 fast-lock
    always_comb begin
        out_d = 1'b0;
        oe_d = 1'b1;
        rst_first_d = 1'b0;
        rst_second_d = 1'b0;
        case (sel_d)
            `SEL_SECOND_REF_A, `SEL_SECOND_REF_B: out_d = s[4];
            `SEL_FIRST_REF_A, `SEL_FIRST_REF_B: out_d = s[6];
            `SEL_SECOND_FB_A, `SEL_SECOND_FB_B: out_d = s[3];
            `SEL_FIRST_FB_A, `SEL_FIRST_FB_B: out_d = s[5];
            `SEL_SECOND_LOCK: out_d = s[1];
            `SEL_FIRST_LOCK: out_d = s[2];
            `SEL_BOTH_LOCK: out_d = s[2] & s[1];
            `SEL_FAST_LOCK: begin
                // Open drain: pull low while fast-lock runs, else release
                out_d = 1'b0;
                oe_d = s[0];
            end
            `SEL_RESET_SECOND: rst_second_d = 1'b1;
            `SEL_RESET_FIRST: rst_first_d = 1'b1;
            `SEL_RESET_ALL: begin
                rst_first_d = 1'b1;
                rst_second_d = 1'b1;
            end
            default: out_d = 1'b0;
        endcase
    end

    // Channel settings, power state and charge pump state
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            first_cfg <= '0;
            first_pd_state <= synth_pkg::pd_active;
            charge_pump_hiz <= 1'b0;
        end else begin
            first_cfg <= cfg_d;
            first_pd_state <= pd_d;
            charge_pump_hiz <= cfg_d.hiz;
        end
    end

    // Select word and the second channel bits that feed it
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            multi_function_output_select <= `SEL_LOW;
            second_ref_bit20 <= 1'b0;
            second_ref_bit21 <= 1'b0;
        end else begin
            multi_function_output_select <= sel_d;
            second_ref_bit20 <= second_sel_hi_q;
            second_ref_bit21 <= second_sel_lo_q;
        end
    end

    // Pin level and enable; low enable releases the open-drain pin
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mf_out <= 1'b0;
            mf_oe <= 1'b1;
        end else begin
            mf_out <= out_d;
            mf_oe <= oe_d;
        end
    end

    // Counter holds stay up for as long as a reset code is selected
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            first_counter_reset <= 1'b0;
            second_counter_reset <= 1'b0;
        end else begin
            first_counter_reset <= rst_first_d;
            second_counter_reset <= rst_second_d;
        end
    end
endmodule

// file: test/serial_host.sv
// Purpose: Host model on the three-wire programming link
// Assumes: 12 ns link clock that runs only while a word shifts
// Notes: Data has no pull, so it shows the inverse once released
`timescale 1ns/1ps
module serial_host (
    output logic link_clk, // Serial clock
    output logic serial_data, // Serial data
    output logic latch_enable // Latch pin
);
    initial begin
        link_clk = 1'b0;
        serial_data = 1'b0;
        latch_enable = 1'b0;
    end
    task automatic send(input logic [21:0] w);
        for (int i = 21; i >= 0; i--) begin
            #3 serial_data = w[i];
            #3 link_clk = 1'b1;
            #6 link_clk = 1'b0;
        end
        #3 latch_enable = 1'b1;
        serial_data = ~serial_data;
        #160 latch_enable = 1'b0;
        #20;
    endtask
endmodule

// file: test/channel_control_assertions.sv
// Purpose: Port checks of channel_control
// Assumes: Outputs settle within five ref_clk cycles of a change
// Notes: Bound to every channel_control instance
`timescale 1ns/1ps
module channel_control_chk (
    input wire logic ref_clk, // Clock
    input wire logic nrst, // Reset
    input wire logic latch_enable, // Latch
    input wire logic first_ref_div_out, // Source
    input wire logic first_fb_div_out, // Source
    input wire logic second_ref_div_out, // Source
    input wire logic second_fb_div_out, // Source
    input wire logic first_lock, // Source
    input wire logic second_lock, // Source
    input wire logic fast_lock_active, // Source
    input wire synth_pkg::channel_cfg_t first_cfg, // Settings
    input wire synth_pkg::pd_state_t first_pd_state, // Power
    input wire logic charge_pump_hiz, // Pump off
    input wire logic [3:0] multi_function_output_select, // Select
    input wire logic mf_out, // Pin level
    input wire logic mf_oe, // Pin enable
    input wire logic first_counter_reset, // Hold
    input wire logic second_counter_reset, // Hold
    input wire logic second_ref_bit20, // Copy
    input wire logic second_ref_bit21 // Copy
);
    wire logic [3:0] sel = multi_function_output_select;
    logic pin;
    always_comb begin
        case (sel)
            4'h1, 4'h9: pin = second_ref_div_out;
            4'h2, 4'ha: pin = first_ref_div_out;
            4'h4: pin = second_lock;
            4'h5, 4'hd: pin = second_fb_div_out;
            4'h6, 4'he: pin = first_fb_div_out;
            4'h8: pin = first_lock;
            4'hc: pin = first_lock & second_lock;
            default: pin = 1'b0;
        endcase
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_pin_level: assert property (($stable(sel) && $stable(pin))[*5]
        |-> mf_out == pin) else $error("pin level wrong");
    a_fast_drain: assert property ((sel == 4'h3
        && $stable(fast_lock_active))[*5]
        |-> mf_oe == fast_lock_active && !mf_out) else $error("drain wrong");
    a_push_pull: assert property (($stable(sel) && sel != 4'h3)[*2]
        |-> mf_oe) else $error("pin not driven");
    a_reset_codes: assert property ($stable(sel)[*2] |->
        first_counter_reset == (sel == 4'hb || sel == 4'hf)
        && second_counter_reset == (sel == 4'h7 || sel == 4'hf))
        else $error("counter hold wrong");
    a_select_bits: assert property (($stable(sel)
        && $stable({second_ref_bit20, second_ref_bit21}))[*2]
        |-> sel[2] == second_ref_bit20 && sel[0] == second_ref_bit21)
        else $error("select bits wrong");
    a_power_state: assert property ($stable(first_cfg)[*2] |->
        first_pd_state == 4'h1 << {first_cfg.channel_powerdown,
        first_cfg.hiz}) else $error("power state wrong");
    a_hiz_level: assert property ($stable(first_cfg)[*2] |->
        charge_pump_hiz == first_cfg.hiz) else $error("pump state wrong");
    a_hold_loaded: assert property ((!latch_enable)[*8] |->
        $stable(first_cfg) && $stable(sel)) else $error("changed unloaded");
    c_drain: cover property (sel == 4'h3 && mf_oe);
    c_async: cover property (first_pd_state == synth_pkg::pd_async);
    c_hold_all: cover property (first_counter_reset && second_counter_reset);
endmodule
bind channel_control channel_control_chk chk (.ref_clk, .nrst,
    .latch_enable, .first_ref_div_out, .first_fb_div_out,
    .second_ref_div_out, .second_fb_div_out, .first_lock, .second_lock,
    .fast_lock_active, .first_cfg, .first_pd_state, .charge_pump_hiz,
    .multi_function_output_select, .mf_out, .mf_oe, .first_counter_reset,
    .second_counter_reset, .second_ref_bit20, .second_ref_bit21);

// file: test/tb_top.sv
// Purpose: Self-checking bench of channel_control
// Assumes: A load settles while latch_enable is still high
// Notes: Writer queues notes; a monitor pops and compares them
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        synth_pkg::channel_cfg_t cfg;
        logic [3:0] sel;
        logic [1:0] rst;
        logic [3:0] pd;
    } note_t;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic link_clk;
    logic serial_data;
    logic latch_enable;
    logic [6:0] src = 7'h00;
    synth_pkg::channel_cfg_t first_cfg;
    synth_pkg::pd_state_t first_pd_state;
    logic [3:0] mosel;
    logic [1:0] rst_o;
    logic [2:0] aux_o;
    synth_pkg::channel_cfg_t cfg_m = '0;
    logic [3:0] sel_m = 4'h0;
    note_t notes[$];
    int mismatches = 0;
    int cmp_count = 0;
    int seed = 32'hc5c30e53;
    logic [19:0] d;
    logic [1:0] a;
    event take;
    serial_host host (.link_clk, .serial_data, .latch_enable);
    channel_control dut (.ref_clk, .nrst, .link_clk, .serial_data,
        .latch_enable, .first_ref_div_out(src[0]), .first_fb_div_out(src[1]),
        .second_ref_div_out(src[2]), .second_fb_div_out(src[3]),
        .first_lock(src[4]), .second_lock(src[5]),
        .fast_lock_active(src[6]), .first_cfg, .first_pd_state,
        .charge_pump_hiz(aux_o[2]), .multi_function_output_select(mosel),
        .mf_out(), .mf_oe(), .first_counter_reset(rst_o[1]),
        .second_counter_reset(rst_o[0]), .second_ref_bit20(aux_o[1]),
        .second_ref_bit21(aux_o[0]));
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        forever begin
            repeat (8) @(posedge ref_clk);
            #1 src = 7'($random(seed));
        end
    end
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [1:0] ad, input logic [19:0] dv);
        note_t n;
        host.send({dv, ad});
        case (ad)
            2'h0: {sel_m[0], sel_m[2]} = dv[19:18];
            2'h2: begin
                {cfg_m.hiz, cfg_m.charge_pump_gain_select,
                    cfg_m.phase_detector_polarity,
                    cfg_m.reference_divider_value} = dv[17:0];
                {sel_m[1], sel_m[3]} = dv[19:18];
            end
            2'h3: {cfg_m.channel_powerdown, cfg_m.prescaler_128,
                cfg_m.binary_feedback_count, cfg_m.swallow_count} = dv;
            default: ;
        endcase
        n.cfg = cfg_m;
        n.sel = sel_m;
        n.rst = {sel_m == 4'hb || sel_m == 4'hf, sel_m == 4'h7 || sel_m == 4'hf};
        n.pd = 4'h1 << {cfg_m.channel_powerdown, cfg_m.hiz};
        notes.push_back(n);
        @(posedge ref_clk);
        #1 -> take;
    endtask
    always @(take) begin
        note_t e;
        note_t g;
        e = notes.pop_front();
        g = {first_cfg, mosel, rst_o, first_pd_state};
        check(48'(g.cfg), 48'(e.cfg));
        check(48'(g[9:0]), 48'(e[9:0]));
        check(48'(aux_o),
            48'({e.cfg.hiz, e.sel[2], e.sel[0]}));
    end
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        #1 nrst = 1'b1;
        put(2'h1, 20'hfffff); // Ignored word leaves reset state
        put(2'h2, 20'h07fff); // Largest reference ratio
        put(2'h3, 20'hfffff); // Largest counts, powered down
        put(2'h3, 20'h00180); // Smallest binary count, no swallow
        for (int i = 0; i < 20; i++) begin
            d = 20'($random(seed));
            a = 2'($random(seed));
            if (a == 2'h2 && d[14:0] < 15'h0003) d[1:0] = 2'h3;
            if (a == 2'h3 && d[17:7] < 11'h003) d[8:7] = 2'h3;
            put(a, d);
        end
        for (int c = 0; c < 16; c++) begin
            d = 20'($random(seed));
            put(2'h2, {c[1], c[3], d[17:2], 2'h3});
            put(2'h0, {c[0], c[2], d[17:0]});
            repeat (40) @(posedge ref_clk);
        end
        conclude();
    end
endmodule
